// [src/clock_phase_diag_access.v]
/*
 Diagnostic load and readback path of the clock-phase generator and the
 acquisition address counter, reached by software over an APB slave.
 Assumes a 10 MHz clk_i, a synchronous active-low reset and an APB
 master on the same clock; the controller keeps the test sequence.
*/
`timescale 1ns/1ps
`include "clock_phase_diag_consts.vh"

module clock_phase_diag_access #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // APB slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [`ADDR_W-1:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg pready_o,
   output reg [31:0] prdata_o,
   output reg pslverr_o,
   // Diagnostic strobes
   output reg step_pulse_n_o,
   output reg readback_strobe_n_o,
   // Control levels
   output reg diag_step_enable_o,
   output reg phase_load_enable_n_o,
   // Internal state views
   output wire [WIDTH-1:0] internal_data_bus_o,
   output wire [WIDTH-1:0] phase_o,
   output wire [WIDTH-1:0] acq_address_counter_o,
   output wire overflow_o
);

   // Registers
   reg [7:0] ctrl_reg;
   reg [7:0] ctrl_next;
   reg [WIDTH-1:0] data_reg;
   reg [WIDTH-1:0] data_next;
   reg step_reg;
   reg step_next;
   reg [31:0] rdata_next;
   reg err_next;
   reg [7:0] phase_view;
   reg [WIDTH-1:0] count_view;

   // Decode
   wire access;
   wire wr_commit;
   wire rd_access;
   wire [7:0] idx;
   wire aligned;
   wire [3:0] phase_code;
   wire [WIDTH-1:0] phase_val;
   wire [WIDTH-1:0] count_val;
   wire overflow_val;

   // Port decode shared by read and write paths
   function valid_port;
      input [7:0] i;
      input wr;
      begin
         case (i)
            `PORT_OVF_IDX: valid_port = !wr;
            `PORT_ADDR_IDX: valid_port = !wr;
            `PORT_PHASE_IDX: valid_port = 1'b1;
            `PORT_DATA_IDX: valid_port = 1'b1;
            `PORT_CTRL_IDX: valid_port = 1'b1;
            default: valid_port = 1'b0;
         endcase
      end
   endfunction

   // Access phase waiting for its answer; one wait state is inserted
   assign access = psel_i & penable_i & ~pready_o;
   // A write lands only at the edge where the master samples ready high
   assign wr_commit = psel_i & penable_i & pready_o & pwrite_i & aligned;
   assign rd_access = access & ~pwrite_i;
   assign idx = paddr_i[`IDX_MSB:`IDX_LSB];
   assign aligned = (paddr_i[1:0] == 2'b00) && (paddr_i[`ADDR_W-1:`IDX_MSB+1] == 2'b00);

   // State views come straight from the flip-flops below
   assign internal_data_bus_o = data_reg;
   assign phase_o = phase_val;
   assign acq_address_counter_o = count_val;
   assign overflow_o = overflow_val;

   // Phase generator; the step enables one update on the pulse cycle
   phase_generator #(
      .WIDTH(WIDTH)
   ) u_phase (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .step_i(step_reg),
      .load_n_i(phase_load_enable_n_o),
      .shift_i(ctrl_reg[`CTRL_SHIFT_BIT]),
      .data_i(data_reg),
      .phase_o(phase_val),
      .code_o(phase_code)
   );

   // Address counter clocked by the lowest phase output
   address_counter #(
      .WIDTH(WIDTH)
   ) u_addr (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .phase_zero_i(phase_val[0]),
      .load_n_i(ctrl_reg[`CTRL_ADDR_HOLD_BIT]),
      .data_i(data_reg),
      .count_o(count_val),
      .overflow_o(overflow_val)
   );

   // Write landing on one given port
   function port_write;
      input en;
      input [7:0] i;
      input [7:0] port;
      begin
         port_write = en && (i == port);
      end
   endfunction

   // Control port write, taken at the edge where the master sees ready
   always @* begin
      ctrl_next = ctrl_reg;
      if (port_write(wr_commit, idx, `PORT_CTRL_IDX)) begin
         ctrl_next = pwdata_i[7:0];
      end
   end

   // Data byte: the data port, and the step port whose byte the step captures
   always @* begin
      data_next = data_reg;
      if (port_write(wr_commit, idx, `PORT_DATA_IDX) || port_write(wr_commit, idx, `PORT_PHASE_IDX)) begin
         data_next = pwdata_i[WIDTH-1:0];
      end
   end

   // Step request from a step port write, only while stepping is enabled
   always @* begin
      step_next = 1'b0;
      if (port_write(wr_commit, idx, `PORT_PHASE_IDX)) begin
         step_next = ctrl_reg[`CTRL_STEP_EN_BIT];
      end
   end

   // Phase code view, present only while the memory access enable is high
   always @* begin
      phase_view = 8'h00;
      if (ctrl_reg[`CTRL_ACCESS_BIT]) begin
         phase_view[7:4] = phase_code;
      end
   end

   // Counter view, routed only while the memory access enable is low
   always @* begin
      count_view = {WIDTH{1'b0}};
      if (!ctrl_reg[`CTRL_ACCESS_BIT]) begin
         count_view = count_val;
      end
   end

   // Refusal: unmapped, misaligned or read-only target
   always @* begin
      err_next = 1'b0;
      if (access) begin
         err_next = !(aligned && valid_port(idx, pwrite_i));
      end
   end

   // Read path: select the value for the addressed read port
   always @* begin
      rdata_next = 32'h0000_0000;
      if (rd_access && aligned) begin
         case (idx)
            `PORT_PHASE_IDX: begin
               rdata_next[7:0] = phase_view;
            end
            `PORT_ADDR_IDX: begin
               rdata_next[WIDTH-1:0] = count_view;
            end
            `PORT_OVF_IDX: begin
               rdata_next[0] = overflow_val;
            end
            `PORT_DATA_IDX: begin
               rdata_next[WIDTH-1:0] = data_reg;
            end
            `PORT_CTRL_IDX: begin
               rdata_next[7:0] = ctrl_reg;
            end
            default: begin
               rdata_next = 32'h0000_0000;
            end
         endcase
      end
   end

   // Ready: one cycle, at the edge after the access phase is taken
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         pready_o <= 1'b0;
      end else begin
         pready_o <= access;
      end
   end

   // Read data, presented together with ready
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         prdata_o <= 32'h0000_0000;
      end else begin
         prdata_o <= rdata_next;
      end
   end

   // Error flag, presented together with ready
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         pslverr_o <= 1'b0;
      end else begin
         pslverr_o <= err_next;
      end
   end

   // Control register
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl_reg <= `CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // Data byte driving the internal data bus
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         data_reg <= `DATA_RESET;
      end else begin
         data_reg <= data_next;
      end
   end

   // Step request; enables one phase update in the following cycle
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         step_reg <= 1'b0;
      end else begin
         step_reg <= step_next;
      end
   end

   // Step pulse: low for the single cycle in which the phase register steps
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         step_pulse_n_o <= 1'b1;
      end else begin
         step_pulse_n_o <= ~step_next;
      end
   end

   // Readback strobe: low while the read answer is being presented
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         readback_strobe_n_o <= 1'b1;
      end else begin
         readback_strobe_n_o <= ~rd_access;
      end
   end

   // Step enable level follows control bit 7
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         diag_step_enable_o <= 1'b0;
      end else begin
         diag_step_enable_o <= ctrl_next[`CTRL_STEP_EN_BIT];
      end
   end

   // Load enable: low only while control bits 0 and 4 are both zero
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         phase_load_enable_n_o <= 1'b0;
      end else begin
         phase_load_enable_n_o <= ctrl_next[`CTRL_SHIFT_BIT] | ctrl_next[`CTRL_PHASE_HOLD_BIT];
      end
   end

endmodule // clock_phase_diag_access

// [src/clock_phase_diag_consts.vh]
/*
 Constants for the clock-phase diagnostic access block: port indices,
 control field positions, reset values, bus geometry and the step pulse width.
 Assumes it is included by bare name and holds definitions only.
*/
`ifndef CLOCK_PHASE_DIAG_CONSTS_VH
`define CLOCK_PHASE_DIAG_CONSTS_VH

// Port indices; byte address on the bus is four times the index
`define PORT_OVF_IDX 8'h02
`define PORT_ADDR_IDX 8'h03
`define PORT_PHASE_IDX 8'h04
`define PORT_DATA_IDX 8'h05
`define PORT_CTRL_IDX 8'h0c

// Control port field positions
`define CTRL_SHIFT_BIT 0
`define CTRL_ADDR_HOLD_BIT 1
`define CTRL_PHASE_HOLD_BIT 4
`define CTRL_ACCESS_BIT 6
`define CTRL_STEP_EN_BIT 7

// Reset values
`define CTRL_RESET 8'h00
`define DATA_RESET 8'h00
`define PHASE_RESET 8'h00
`define ADDR_RESET 8'h00

// Bus geometry
`define ADDR_W 12
`define IDX_LSB 2
`define IDX_MSB 9

// Step pulse width in cycles of the 100 ns clock
`define STEP_PULSE_CYCLES 1

`endif

// [src/phase_generator.v]
/*
 Eight-bit clock-phase generator: parallel load or left rotate on a step,
 hold otherwise, plus its encoded readback code.
 Assumes one clock, a synchronous active-low reset and a one-cycle step.
*/
`timescale 1ns/1ps
`include "clock_phase_diag_consts.vh"

module phase_generator #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Step control
   input wire step_i,
   input wire load_n_i,
   input wire shift_i,
   input wire [WIDTH-1:0] data_i,
   // State
   output reg [WIDTH-1:0] phase_o,
   output reg [3:0] code_o
);

   reg [WIDTH-1:0] phase_next;

   // One-hot to code: top bit marks a one, low bits give its position
   function [3:0] encode;
      input [WIDTH-1:0] v;
      integer i;
      begin
         encode = 4'h0;
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (v[i]) begin
               encode = {1'b1, i[2:0]};
            end
         end
      end
   endfunction

   // Next contents: only a step may change them
   always @* begin
      phase_next = phase_o;
      if (step_i) begin
         if (!load_n_i) begin
            phase_next = data_i;
         end else if (shift_i) begin
            phase_next = {phase_o[WIDTH-2:0], phase_o[WIDTH-1]};
         end
      end
   end

   // Contents and code registers
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         phase_o <= `PHASE_RESET;
         code_o <= 4'h0;
      end else begin
         phase_o <= phase_next;
         code_o <= encode(phase_next);
      end
   end

endmodule // phase_generator

// [src/address_counter.v]
/*
 First-stage acquisition address counter with overflow flag.
 Assumes the phase generator's lowest bit as its clock source, sampled
 on the same system clock; a rising edge of that bit loads or counts.
*/
`timescale 1ns/1ps
`include "clock_phase_diag_consts.vh"

module address_counter #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Counter control
   input wire phase_zero_i,
   input wire load_n_i,
   input wire [WIDTH-1:0] data_i,
   // State
   output reg [WIDTH-1:0] count_o,
   output reg overflow_o
);

   reg phase_zero_reg;
   wire tick;

   // Rising edge of the lowest phase output is the counter clock
   assign tick = phase_zero_i & ~phase_zero_reg;

   // Load from the internal bus or count up; overflow is sticky until a load
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         phase_zero_reg <= 1'b0;
         count_o <= `ADDR_RESET;
         overflow_o <= 1'b0;
      end else begin
         phase_zero_reg <= phase_zero_i;
         if (tick) begin
            if (!load_n_i) begin
               count_o <= data_i;
               overflow_o <= 1'b0;
            end else begin
               count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
               if (&count_o) begin
                  overflow_o <= 1'b1;
               end
            end
         end
      end
   end

endmodule // address_counter

// [tb/clock_phase_diag_properties.sv]
/*
 Checker of step, load and readback timing at the block's ports.
 Assumes it is bound to clock_phase_diag_access.
*/
`timescale 1ns/1ps
`include "clock_phase_diag_consts.vh"

module clock_phase_diag_checker #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // APB
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [`ADDR_W-1:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire pready_o,
   input wire [31:0] prdata_o,
   input wire pslverr_o,
   // Strobes and levels
   input wire step_pulse_n_o,
   input wire readback_strobe_n_o,
   input wire diag_step_enable_o,
   input wire phase_load_enable_n_o,
   // State views
   input wire [WIDTH-1:0] internal_data_bus_o,
   input wire [WIDTH-1:0] phase_o,
   input wire [WIDTH-1:0] acq_address_counter_o,
   input wire overflow_o
);
   // Completed transfers and their port index
   wire [7:0] idx = paddr_i[`IDX_MSB:`IDX_LSB];
   wire done = psel_i && penable_i && pready_o;
   wire wr_done = done && pwrite_i;
   wire rd_done = done && !pwrite_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_read_strobe: assert property (rd_done && !pslverr_o |-> !readback_strobe_n_o)
      else $error("read strobe missing");
   chk_step_pulse: assert property (wr_done && idx == `PORT_PHASE_IDX && diag_step_enable_o
      |=> !step_pulse_n_o ##1 step_pulse_n_o) else $error("step pulse wrong");
   chk_step_cause: assert property ($fell(step_pulse_n_o) |-> $past(wr_done) && $past(diag_step_enable_o))
      else $error("step without enable");
   chk_phase_hold: assert property (step_pulse_n_o |=> $stable(phase_o))
      else $error("phase moved without step");
   chk_phase_load: assert property (!step_pulse_n_o && !phase_load_enable_n_o
      |=> phase_o == $past(internal_data_bus_o)) else $error("phase load wrong");
   chk_ctrl_levels: assert property (wr_done && idx == `PORT_CTRL_IDX |-> ##2
      phase_load_enable_n_o == ($past(pwdata_i[0], 2) | $past(pwdata_i[4], 2))
      && diag_step_enable_o == $past(pwdata_i[7], 2)) else $error("control levels wrong");
   chk_count_clock: assert property (!$stable(acq_address_counter_o) && $past(rst_n_i)
      |-> $past(phase_o[0]) && !$past(phase_o[0], 2)) else $error("counter moved off clock");
   chk_ovf_read: assert property (rd_done && idx == `PORT_OVF_IDX && !pslverr_o
      |-> prdata_o == {31'h0, overflow_o}) else $error("overflow read wrong");
endmodule // clock_phase_diag_checker

// [tb/apb_controller_model.sv]
/*
 Controller model: an APB master making one transfer per call.
 Assumes the slave answers with pready; the bench bounds the wait.
*/
`timescale 1ns/1ps
`include "clock_phase_diag_consts.vh"

module apb_controller_model (
   // Clock and answer
   input wire clk_i,
   input wire pready_i,
   input wire [31:0] prdata_i,
   input wire pslverr_i,
   // Request
   output logic psel_o = 1'b0,
   output logic penable_o = 1'b0,
   output logic pwrite_o = 1'b0,
   output logic [`ADDR_W-1:0] paddr_o = 12'h000,
   output logic [31:0] pwdata_o = 32'h0
);
   // Setup, access until pready, then release
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge clk_i);
      psel_o <= 1'b1;
      pwrite_o <= wr;
      paddr_o <= {2'b00, idx, 2'b00};
      pwdata_o <= {24'h0, wd}; // Byte rides in the low lane
      @(posedge clk_i);
      penable_o <= 1'b1;
      do @(posedge clk_i); while (pready_i !== 1'b1);
      rd = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      paddr_o <= ~paddr_o; // Released lines do not keep their value
      pwdata_o <= ~pwdata_o;
   endtask
endmodule // apb_controller_model

// [tb/tb.sv]
/*
 Bench: phase walk, counter load and count, gating and refusals.
 Assumes the controller model and the bound checker.
*/
`timescale 1ns/1ps
`include "clock_phase_diag_consts.vh"

module tb;
   // Clock, reset and bus wires
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   wire psel, penable, pwrite, pready, pslverr, ovf;
   wire [`ADDR_W-1:0] paddr;
   wire [31:0] pwdata, prdata;
   wire [7:0] phase, cnt;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [31:0] rdata;
   logic err;
   logic [7:0] d;
   always #50 clk_i = ~clk_i;

   apb_controller_model ctl (.clk_i(clk_i), .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr),
      .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
   clock_phase_diag_access #(.WIDTH(8)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
      .prdata_o(prdata), .pslverr_o(pslverr), .step_pulse_n_o(), .readback_strobe_n_o(),
      .diag_step_enable_o(), .phase_load_enable_n_o(), .internal_data_bus_o(), .phase_o(phase),
      .acq_address_counter_o(cnt), .overflow_o(ovf));

   // Comparison, bus shorthands and closing
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] idx, input logic [7:0] v);
      ctl.xfer(1'b1, idx, v, rdata, err);
   endtask
   task rd(input logic [7:0] idx);
      ctl.xfer(1'b0, idx, 8'h00, rdata, err);
   endtask
   task ld_cnt(input logic [7:0] v);
      wr(`PORT_CTRL_IDX, 8'hc0);
      wr(`PORT_PHASE_IDX, 8'h80);
      wr(`PORT_CTRL_IDX, 8'h81);
      wr(`PORT_PHASE_IDX, v);
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         report_and_stop;
      end
   end

   // Test sequence
   initial begin
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         d = (i < 8) ? (8'h80 >> i) : 8'h00;
         wr(`PORT_CTRL_IDX, 8'hc0);
         wr(`PORT_PHASE_IDX, d);
         rd(`PORT_PHASE_IDX);
         check(rdata, (i < 8) ? {24'h0, 4'hf - i[3:0], 4'h0} : 32'h0);
         check({24'h0, phase}, {24'h0, d});
         ld_cnt(d);
         rd(`PORT_ADDR_IDX);
         check(rdata, {24'h0, d});
         check({24'h0, phase}, 32'h01);
      end
      $display("walk test done");
      wr(`PORT_CTRL_IDX, 8'h41);
      wr(`PORT_PHASE_IDX, 8'h55);
      rd(`PORT_PHASE_IDX);
      check(rdata, 32'h80);
      rd(`PORT_ADDR_IDX);
      check(rdata, 32'h0);
      wr(`PORT_CTRL_IDX, 8'h01);
      rd(`PORT_PHASE_IDX);
      check(rdata, 32'h0);
      $display("gating test done");
      ld_cnt(8'hff);
      rd(`PORT_OVF_IDX);
      check(rdata, 32'h0);
      wr(`PORT_CTRL_IDX, 8'h83);
      repeat (8) wr(`PORT_PHASE_IDX, 8'h00);
      rd(`PORT_OVF_IDX);
      check(rdata, 32'h1);
      rd(`PORT_ADDR_IDX);
      check(rdata, 32'h0);
      $display("overflow test done");
      wr(`PORT_ADDR_IDX, 8'h12);
      check({31'h0, err}, 32'h1);
      rd(8'h07);
      check({31'h0, err}, 32'h1);
      $display("refusal test done");
      report_and_stop;
   end
endmodule // tb

bind clock_phase_diag_access clock_phase_diag_checker #(.WIDTH(WIDTH)) u_chk (.clk_i(clk_i),
   .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
   .step_pulse_n_o(step_pulse_n_o), .readback_strobe_n_o(readback_strobe_n_o),
   .diag_step_enable_o(diag_step_enable_o), .phase_load_enable_n_o(phase_load_enable_n_o),
   .internal_data_bus_o(internal_data_bus_o), .phase_o(phase_o),
   .acq_address_counter_o(acq_address_counter_o), .overflow_o(overflow_o));
